// ### mtpos_pkg.sv
// Constants and types for the multi-turn absolute position core.
// Assumes a single 10 MHz clock and an active-low power-on reset.
// What this block does
// R1 - The shaft angle is held as a 17-bit unsigned count from 0 to 131071 per turn.
// R2 - The turn count is held as a 16-bit unsigned value from 0 to 65535.
// R3 - In normal state both angle and turn count are computed and link traffic is served.
// R4 - After main power returns the link need not answer until 550 ms have passed.
// R5 - In battery backup state the turn count keeps being updated.
// R6 - In battery backup state nothing is sent or taken on the link.
// R7 - With neither supply good all operation halts and the turn count error flag is set.
// R8 - The error flag lasts until the controller clears it and is reported in replies until then.
// R9 - The link is one controller to one device, half duplex, one driver at a time.
// R10 - A reply is sent only in answer to a command from the controller.
// R11 - Angle and turn count stay correct up to 6000 turns per minute.
// R12 - The turn count steps up on a forward wrap, down on a backward wrap, modulo 65536.
// R13 - The state is chosen from main-good and battery-good inputs, main first.
package mtpos_pkg;
   // ==========================================================
   // Widths
   localparam int ANGLE_W = 17;
   localparam int TURN_W = 16;
   localparam logic [16:0] ANGLE_MAX = 17'h1ffff;
   localparam logic [15:0] TURN_MAX = 16'hffff;
   // ==========================================================
   // Timing
   localparam longint CLK_HZ = 10_000_000;
   localparam longint STARTUP_MS = 550;
   // Longest wait, rounded down to whole cycles
   localparam longint STARTUP_CYCLES = (STARTUP_MS * CLK_HZ) / 1000;
   localparam int STARTUP_W = 23;
   localparam longint MAX_RPM = 6000;
   // Counts moved per clock at top speed; must stay below a quarter turn
   localparam longint MAX_STEP = ((MAX_RPM << ANGLE_W) + 60 * CLK_HZ - 1) / (60 * CLK_HZ);
   localparam int REPLY_CYCLES = 8;
   localparam logic [3:0] REPLY_CNT = 4'h8;
   // ==========================================================
   // Reset values
   localparam logic [16:0] ANGLE_RST = 17'h00000;
   localparam logic [15:0] TURN_RST = 16'h0000;
   // ==========================================================
   // Operating states
   typedef enum logic [1:0] {
      MTPOS_NORMAL = 2'b00,
      MTPOS_BACKUP = 2'b01,
      MTPOS_HALT = 2'b10
   } mtpos_state_e;
endpackage

// ### mtpos_core.sv
// Position core: angle and turn keeping, supply states, error flag, reply gating.
// Assumes the reset comes from the always-on battery domain, supply-good pins are
// asynchronous, and the sensor and frame decoder run on clk_i.
`timescale 1ns/1ps
`default_nettype none
module mtpos_core #(
   parameter longint STARTUP_CYCLES = mtpos_pkg::STARTUP_CYCLES
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Supply status pins
   input wire logic main_good_i,
   input wire logic bat_good_i,
   // Sensor angle sample
   input wire logic [16:0] angle_i,
   // Decoded command from the link receiver
   input wire logic cmd_valid_i,
   input wire logic cmd_clear_err_i,
   // Position and status
   output logic [16:0] angle_o,
   output logic [15:0] turns_o,
   output logic [1:0] state_o,
   output logic revolution_count_error_flag_o,
   output logic link_ready_o,
   // Reply to the link transmitter
   output logic reply_valid_o,
   output logic [16:0] reply_angle_o,
   output logic [15:0] reply_turns_o,
   output logic reply_error_o,
   output logic tx_en_o
);
   // Refuse a wait the counter cannot hold, or a top speed that hides wraps
   if (STARTUP_CYCLES < 1 ||
         STARTUP_CYCLES >= (64'h1 << mtpos_pkg::STARTUP_W)) begin : g_bad_wait
      $error("STARTUP_CYCLES out of range");
   end
   if (mtpos_pkg::MAX_STEP >= (64'h1 << (mtpos_pkg::ANGLE_W - 2))) begin : g_bad_speed
      $error("Top speed too fast for wrap detection");
   end

   localparam logic [22:0] STARTUP_LAST = 23'(STARTUP_CYCLES - 1);

   // ==========================================================
   // Supply pin synchronisers
   // Only the second stage is read by the logic
   logic [1:0] main_sync_q, main_sync_d;
   logic [1:0] bat_sync_q, bat_sync_d;
   always_comb begin
      main_sync_d = {main_sync_q[0], main_good_i};
      bat_sync_d = {bat_sync_q[0], bat_good_i};
   end
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         main_sync_q <= 2'h0;
         bat_sync_q <= 2'h0;
      end else begin
         main_sync_q <= main_sync_d;
         bat_sync_q <= bat_sync_d;
      end
   end
   logic main_ok, bat_ok;
   assign main_ok = main_sync_q[1];
   assign bat_ok = bat_sync_q[1];

   // ==========================================================
   // Operating state
   mtpos_pkg::mtpos_state_e state_q, state_d;
   always_comb begin
      if (main_ok) begin
         state_d = mtpos_pkg::MTPOS_NORMAL; // R13
      end else if (bat_ok) begin
         state_d = mtpos_pkg::MTPOS_BACKUP;
      end else begin
         state_d = mtpos_pkg::MTPOS_HALT; // R7
      end
   end
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_q <= mtpos_pkg::MTPOS_HALT;
      end else begin
         state_q <= state_d;
      end
   end
   logic is_normal;
   assign is_normal = (state_q == mtpos_pkg::MTPOS_NORMAL);

   // ==========================================================
   // Angle and turn tracking
   logic [16:0] angle_q, angle_d;
   logic [16:0] last_q, last_d;
   logic [15:0] turns_q, turns_d;
   logic wrap_up, wrap_dn, counting;
   always_comb begin
      // Top two bits going 11 -> 00 is a forward wrap, 00 -> 11 a backward one
      wrap_up = (last_q[16:15] == 2'h3) && (angle_i[16:15] == 2'h0);
      wrap_dn = (last_q[16:15] == 2'h0) && (angle_i[16:15] == 2'h3);
      counting = (state_q != mtpos_pkg::MTPOS_HALT); // R5
      angle_d = angle_q;
      last_d = last_q;
      turns_d = turns_q;
      if (is_normal) begin
         angle_d = angle_i; // R1 R3
      end
      if (counting) begin
         last_d = angle_i; // R11
         if (wrap_up) begin
            turns_d = turns_q + 16'h0001; // R2 R12
         end else if (wrap_dn) begin
            turns_d = turns_q - 16'h0001; // R12
         end
      end
   end
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         angle_q <= mtpos_pkg::ANGLE_RST;
         last_q <= mtpos_pkg::ANGLE_RST;
         turns_q <= mtpos_pkg::TURN_RST;
      end else begin
         angle_q <= angle_d;
         last_q <= last_d;
         turns_q <= turns_d;
      end
   end

   // ==========================================================
   // Start-up wait after main power returns
   logic [22:0] start_cnt_q, start_cnt_d;
   logic ready_q, ready_d;
   always_comb begin
      start_cnt_d = start_cnt_q;
      ready_d = ready_q;
      // The wait restarts on every entry into normal state
      if (!is_normal) begin
         start_cnt_d = 23'h000000;
         ready_d = 1'b0;
      end else if (!ready_q) begin
         if (start_cnt_q == STARTUP_LAST) begin
            ready_d = 1'b1; // R4
         end else begin
            start_cnt_d = start_cnt_q + 23'h000001;
         end
      end
   end
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         start_cnt_q <= 23'h000000;
         ready_q <= 1'b0;
      end else begin
         start_cnt_q <= start_cnt_d;
         ready_q <= ready_d;
      end
   end

   // ==========================================================
   // Error flag and reply
   logic err_q, err_d;
   logic accept;
   logic [3:0] tx_cnt_q, tx_cnt_d;
   logic tx_en_q, tx_en_d;
   logic rv_q, rv_d;
   logic [16:0] ra_q, ra_d;
   logic [15:0] rt_q, rt_d;
   logic re_q, re_d;
   always_comb begin
      // Commands are ignored while our own reply still holds the line
      accept = cmd_valid_i && is_normal && ready_q && !tx_en_q; // R6 R9 R10
      err_d = err_q;
      if (accept && cmd_clear_err_i) begin
         err_d = 1'b0;
      end
      // Halt sets the flag even when a clear arrives in the same cycle
      if (state_q == mtpos_pkg::MTPOS_HALT) begin
         err_d = 1'b1; // R7
      end
      rv_d = accept;
      ra_d = ra_q;
      rt_d = rt_q;
      re_d = re_q;
      if (accept) begin
         ra_d = angle_q;
         rt_d = turns_q;
         re_d = err_q; // R8
      end
      tx_cnt_d = tx_cnt_q;
      tx_en_d = tx_en_q;
      if (!is_normal) begin
         tx_cnt_d = 4'h0;
         tx_en_d = 1'b0; // R6
      end else if (accept) begin
         tx_cnt_d = mtpos_pkg::REPLY_CNT - 4'h1;
         tx_en_d = 1'b1; // R10
      end else if (tx_en_q) begin
         if (tx_cnt_q == 4'h0) begin
            tx_en_d = 1'b0; // R9
         end else begin
            tx_cnt_d = tx_cnt_q - 4'h1;
         end
      end
   end
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         err_q <= 1'b0;
         tx_cnt_q <= 4'h0;
         tx_en_q <= 1'b0;
         rv_q <= 1'b0;
         ra_q <= mtpos_pkg::ANGLE_RST;
         rt_q <= mtpos_pkg::TURN_RST;
         re_q <= 1'b0;
      end else begin
         err_q <= err_d;
         tx_cnt_q <= tx_cnt_d;
         tx_en_q <= tx_en_d;
         rv_q <= rv_d;
         ra_q <= ra_d;
         rt_q <= rt_d;
         re_q <= re_d;
      end
   end

   assign angle_o = angle_q;
   assign turns_o = turns_q;
   assign state_o = state_q;
   assign revolution_count_error_flag_o = err_q;
   assign link_ready_o = ready_q;
   assign reply_valid_o = rv_q;
   assign reply_angle_o = ra_q;
   assign reply_turns_o = rt_q;
   assign reply_error_o = re_q;
   assign tx_en_o = tx_en_q;

   // ==========================================================
   // Assertions
   angle_hold_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R3
      !is_normal |=> $stable(angle_q))
      else $error("Angle moved outside normal state");
   turn_step_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R12
      counting && wrap_up |=> turns_q == $past(turns_q) + 16'h0001)
      else $error("Turn count missed a forward wrap");
   turn_back_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R5
      counting && wrap_dn |=> turns_q == $past(turns_q) - 16'h0001)
      else $error("Turn count missed a backward wrap");
   halt_freeze_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R7
      state_q == mtpos_pkg::MTPOS_HALT |=> $stable(turns_q) && err_q)
      else $error("Halt did not freeze count and set flag");
   err_keep_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R8
      err_q && !(accept && cmd_clear_err_i) |=> err_q)
      else $error("Error flag lost without a clear");
   err_report_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R8
      accept |=> reply_valid_o && reply_error_o == $past(err_q))
      else $error("Reply did not carry error flag");
   quiet_link_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R6
      $past(state_q) != mtpos_pkg::MTPOS_NORMAL |-> !tx_en_q)
      else $error("Line driven outside normal state");
   no_spont_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R10
      $rose(tx_en_q) |-> $past(accept))
      else $error("Reply without a command");
   startup_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R4
      !ready_q |-> !tx_en_q && !reply_valid_o)
      else $error("Reply before start-up wait ended");
   // Window ends on the eighth driven cycle; the line must drop on the next
   reply_len_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R9
      $rose(tx_en_q) && is_normal ##1 is_normal[*7] |-> tx_en_q ##1 !tx_en_q)
      else $error("Reply drive length wrong");
   main_first_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R13
      main_ok |=> is_normal)
      else $error("Main supply did not win");
   sync_backup_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R13
      !main_ok && bat_ok |=> state_q == mtpos_pkg::MTPOS_BACKUP)
      else $error("Battery state not entered");
   // Tracking and snapshot
   angle_track_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R3
      is_normal |=> angle_q == $past(angle_i))
      else $error("Angle did not follow the sensor");
   turn_keep_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R2
      counting && !wrap_up && !wrap_dn |=> $stable(turns_q))
      else $error("Turn count moved without a wrap");
   reply_snap_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R10
      accept |=> reply_angle_o == $past(angle_q) && reply_turns_o == $past(turns_q))
      else $error("Reply word is not the accepted position");
   // Flag clear, start-up wait and drive length
   err_clear_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R8
      accept && cmd_clear_err_i |=> !err_q)
      else $error("Error flag not cleared on request");
   ready_wait_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R4
      $rose(ready_q) |-> $past(is_normal) && $past(start_cnt_q) == STARTUP_LAST)
      else $error("Link ready before the wait ran out");
   tx_hold_a: assert property (@(posedge clk_i) disable iff (!rst_b_i) // R9
      tx_en_q && tx_cnt_q != 4'h0 && is_normal |=> tx_en_q)
      else $error("Line released before the reply ended");

   // Main scenarios
   ready_c: cover property (@(posedge clk_i) disable iff (!rst_b_i) $rose(ready_q));
   clear_c: cover property (@(posedge clk_i) disable iff (!rst_b_i)
      accept && cmd_clear_err_i);
   reply_c: cover property (@(posedge clk_i) disable iff (!rst_b_i) accept);
   backup_wrap_c: cover property (@(posedge clk_i) disable iff (!rst_b_i)
      state_q == mtpos_pkg::MTPOS_BACKUP && wrap_up);
   err_report_c: cover property (@(posedge clk_i) disable iff (!rst_b_i)
      reply_valid_o && reply_error_o);
endmodule
`default_nettype wire

// ### mtpos_ctrl_model.sv
// Controller model on the far side of the position core's command port.
// Assumes the core answers with a reply pulse and a driver enable on clk_i.
`timescale 1ns/1ps
`default_nettype none
module mtpos_ctrl_model (
   // Clock
   input wire logic clk_i,
   // Device status
   input wire logic ready_i,
   input wire logic tx_en_i,
   // Command to the device
   output logic cmd_valid_o,
   output logic cmd_clear_err_o
);
   initial begin
      cmd_valid_o = 1'b0;
      cmd_clear_err_o = 1'b0;
   end
   // ==========================================================
   // One command; blind skips the wait, to provoke a refusal
   task automatic send(input logic clr, input logic blind, input int gap);
      int w;
      w = 0;
      while (!blind && !(ready_i === 1'b1 && tx_en_i === 1'b0) && w < 50000) begin
         @(posedge clk_i);
         w++;
      end
      repeat (gap + 1) @(posedge clk_i);
      cmd_valid_o <= 1'b1;
      cmd_clear_err_o <= clr;
      @(posedge clk_i);
      cmd_valid_o <= 1'b0;
      cmd_clear_err_o <= 1'b0;
      repeat (9) @(posedge clk_i);
   endtask
endmodule
`default_nettype wire

// ### tb_multiturn_abs_position_core.sv
// Self-checking bench for the position core and its controller model.
// Assumes the package, the core and the controller model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_multiturn_abs_position_core;
   logic clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic main_good_i = 1'b0;
   logic bat_good_i = 1'b0;
   logic [16:0] angle_i = 17'h00000;
   logic cmd_valid_i;
   logic cmd_clear_err_i;
   logic [16:0] angle_o;
   logic [16:0] reply_angle_o;
   logic [15:0] turns_o;
   logic [15:0] reply_turns_o;
   logic [1:0] state_o;
   logic err_o;
   logic link_ready_o;
   logic reply_valid_o;
   logic reply_error_o;
   logic tx_en_o;
   logic [33:0] exp_q[$];
   logic [15:0] m_turns = 16'h0000;
   logic m_err = 1'b0;
   logic [16:0] held_angle = 17'h00000;
   int tx_len = 0;
   int n_mismatch = 0;
   int tests_run = 0;
   always #50 clk_i = ~clk_i;
   // ==========================================================
   mtpos_core #(.STARTUP_CYCLES(20)) DUT (
      .clk_i(clk_i), .rst_b_i(rst_b_i), .main_good_i(main_good_i),
      .bat_good_i(bat_good_i), .angle_i(angle_i), .cmd_valid_i(cmd_valid_i),
      .cmd_clear_err_i(cmd_clear_err_i), .angle_o(angle_o), .turns_o(turns_o),
      .state_o(state_o), .revolution_count_error_flag_o(err_o),
      .link_ready_o(link_ready_o), .reply_valid_o(reply_valid_o),
      .reply_angle_o(reply_angle_o), .reply_turns_o(reply_turns_o),
      .reply_error_o(reply_error_o), .tx_en_o(tx_en_o));
   mtpos_ctrl_model CTRL (
      .clk_i(clk_i), .ready_i(link_ready_o), .tx_en_i(tx_en_o),
      .cmd_valid_o(cmd_valid_i), .cmd_clear_err_o(cmd_clear_err_i));
   // ==========================================================
   task automatic check(input logic [33:0] seen, input logic [33:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict();
      $display("Mismatches %0d, checks %0d", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // Random steps below a quarter turn; the model tracks the turn count
   task automatic move(input int n, input logic back);
      logic [16:0] a;
      int st;
      repeat (n) begin
         @(posedge clk_i);
         a = angle_i;
         st = $urandom_range(1, 28672);
         if (back) begin
            if (int'(a) < st) m_turns = m_turns - 16'h0001;
            angle_i <= a - 17'(st);
         end else begin
            if (int'(a) + st > 131071) m_turns = m_turns + 16'h0001;
            angle_i <= a + 17'(st);
         end
      end
   endtask
   task automatic ask(input logic clr);
      repeat (4) @(posedge clk_i);
      exp_q.push_back({m_err, m_turns, angle_i});
      CTRL.send(clr, 1'b0, $urandom_range(0, 3));
      if (clr) m_err = 1'b0;
      check(34'(state_o), 34'h0);
      check(34'(turns_o), 34'(m_turns));
      check(34'(angle_o), 34'(angle_i));
      check(34'(err_o), 34'(m_err));
      check(34'(link_ready_o), 34'h1);
   endtask
   // ==========================================================
   // Monitor: replies against the oldest note, drive length per reply
   always @(posedge clk_i) begin
      if (reply_valid_o === 1'b1) begin
         if (exp_q.size() == 0) check(34'h1, 34'h0);
         else check({reply_error_o, reply_turns_o, reply_angle_o}, exp_q.pop_front());
      end
      if (tx_en_o === 1'b1) begin
         tx_len++;
      end else if (tx_len != 0) begin
         check(34'(tx_len), 34'h8);
         tx_len = 0;
      end
   end
   initial begin
      #(100 * 30000);
      n_mismatch++;
      print_verdict();
   end
   // ==========================================================
   initial begin
      void'($urandom(32'h6257));
      repeat (2) @(posedge clk_i);
      rst_b_i <= 1'b1;
      main_good_i <= 1'b1;
      bat_good_i <= 1'b1;
      m_err = 1'b1;
      ask(1'b1);
      ask(1'b0);
      move(40, 1'b0);
      ask(1'b0);
      move(60, 1'b1);
      ask(1'b0);
      main_good_i <= 1'b0;
      repeat (6) @(posedge clk_i);
      check(34'(state_o), 34'h1);
      check(34'(link_ready_o), 34'h0);
      held_angle = angle_i;
      move(30, 1'b0);
      repeat (4) @(posedge clk_i);
      check(34'(angle_o), 34'(held_angle));
      check(34'(turns_o), 34'(m_turns));
      CTRL.send(1'b0, 1'b1, 0);
      main_good_i <= 1'b1;
      ask(1'b0);
      main_good_i <= 1'b0;
      bat_good_i <= 1'b0;
      repeat (6) @(posedge clk_i);
      check(34'(state_o), 34'h2);
      check(34'(err_o), 34'h1);
      m_err = 1'b1;
      bat_good_i <= 1'b1;
      main_good_i <= 1'b1;
      ask(1'b1);
      ask(1'b0);
      check(34'(exp_q.size()), 34'h0);
      print_verdict();
   end
endmodule
`default_nettype wire
